// [sqs_pkg.sv]
// Shared constants and types for the sequencer stack slots 12 to 15.
package sqs_pkg;

    // Printed register indices; byte address is four times the index.
    localparam logic [5:0] SQS_IDX_SLOT12 = 6'h2c;
    localparam logic [5:0] SQS_IDX_SLOT13 = 6'h2d;
    localparam logic [5:0] SQS_IDX_SLOT14 = 6'h2e;
    localparam logic [5:0] SQS_IDX_SLOT15 = 6'h2f;
    // Control register of our own: bit 0 enables the walker.
    localparam logic [5:0] SQS_IDX_CTRL = 6'h3c;
    // Status register of our own: current slot and channels.
    localparam logic [5:0] SQS_IDX_STAT = 6'h3d;

    // Number of slots held here.
    localparam int SQS_SLOTS = 4;

    // Field positions inside an entry word.
    localparam int SQS_ACC_BIT = 15;
    localparam int SQS_ADDR_HI = 14;
    localparam int SQS_ADDR_LO = 9;
    localparam int SQS_RET_BIT = 8;
    localparam int SQS_CHB_HI = 7;
    localparam int SQS_CHB_LO = 4;
    localparam int SQS_CHA_HI = 3;
    localparam int SQS_CHA_LO = 0;

    // Reset values of the four entries.
    localparam logic [15:0] SQS_RST_SLOT12 = 16'h5800;
    localparam logic [15:0] SQS_RST_SLOT13 = 16'h5a00;
    localparam logic [15:0] SQS_RST_SLOT14 = 16'h5c00;
    localparam logic [15:0] SQS_RST_SLOT15 = 16'h5e00;
    // Control register resets with the walker disabled.
    localparam logic [31:0] SQS_RST_CTRL = 32'h0000_0000;

    // One entry split into its fields.
    typedef struct packed {
        logic access_write;
        logic [5:0] entry_address_field;
        logic slot_return_flag;
        logic [3:0] converter_b_channel;
        logic [3:0] converter_a_channel;
    } sqs_entry_t;

    // Channel pair handed to the converters.
    typedef struct packed {
        logic [3:0] converter_b_channel;
        logic [3:0] converter_a_channel;
    } sqs_chan_t;

endpackage : sqs_pkg

// [sqs_slots.sv]
`timescale 1ns/1ns
// Operation
// [RULE1] Bit 15 marks read or write access.
// [RULE2] Host puts entry address in bits 14:9.
// [RULE3] Address field resets to own address.
// [RULE4] Return flag clear: advance after conversion.
// [RULE5] Return flag set: back to first slot.
// [RULE6] Bits 7:4 select converter B channel.
// [RULE7] Bits 3:0 select converter A channel.
// [RULE8] All fields read/write; return flag resets zero.
// [RULE9] Channel codes match primary select encoding.
module sqs_slots (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    output sqs_pkg::sqs_chan_t chan_sel,
    output logic [1:0] cur_slot
);
    import sqs_pkg::*;

    // Reset image of one slot, chosen by index.
    function automatic logic [15:0] slot_reset(input int idx);
        unique case (idx)
            0: slot_reset = SQS_RST_SLOT12;
            1: slot_reset = SQS_RST_SLOT13;
            2: slot_reset = SQS_RST_SLOT14;
            default: slot_reset = SQS_RST_SLOT15;
        endcase
    endfunction : slot_reset

    // Word index of an APB byte address; low two bits must be zero.
    function automatic logic [5:0] word_index(input logic [31:0] a);
        word_index = a[7:2];
    endfunction : word_index

    // The four stack entries, held in flip-flops.
    logic [15:0] slot_r [SQS_SLOTS];
    // Walker enable, kept in our own control register.
    logic enable_r;
    // Registered bus answers.
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    // Registered channel outputs to the converters.
    sqs_chan_t chan_r;
    // Slot that the walker points at.
    logic [1:0] walk_idx;

    // Setup phase of a transfer; the answer comes one cycle later.
    wire setup = psel && !penable;
    // Completing access edge, where writes land and reads are taken.
    wire access = psel && penable && pready_r;
    wire [5:0] widx = word_index(paddr);
    // Only aligned words below byte 0x100 are mapped; the rest is refused.
    wire aligned = (paddr[1:0] == 2'h0) && (paddr[31:8] == 24'h0);
    wire hit_slot = aligned && (widx >= SQS_IDX_SLOT12)
                    && (widx <= SQS_IDX_SLOT15);
    wire hit_ctrl = aligned && (widx == SQS_IDX_CTRL);
    wire hit_stat = aligned && (widx == SQS_IDX_STAT);
    // Any hit answers without error unless it is a status write.
    wire mapped = hit_slot || hit_ctrl || hit_stat;
    wire [1:0] sidx = widx[1:0] - SQS_IDX_SLOT12[1:0];
    // Status is read-only, so a write to it is answered with an error.
    wire bad = !mapped || (hit_stat && pwrite);
    // Entry under the walker, seen as fields.
    wire sqs_entry_t cur_entry = sqs_entry_t'(slot_r[walk_idx]);
    // Channel fields of the entry under the walker.
    wire [3:0] chan_b_pick = cur_entry.converter_b_channel; // [RULE6]
    wire [3:0] chan_a_pick = cur_entry.converter_a_channel; // [RULE7]

    // Read data chosen during setup so it is ready for the access edge.
    wire [31:0] rd_mux = hit_slot ? {16'h0, slot_r[sidx]} :
                         hit_ctrl ? {31'h0, enable_r} :
                         hit_stat ? {22'h0, walk_idx, chan_r} :
                         32'h0;

    // Entry slots; every field is writable and the reset image holds
    // the entry's own address with all other fields zero.
    for (genvar g = 0; g < SQS_SLOTS; g++) begin : g_slot
        // Reset image of this slot, fixed at elaboration.
        localparam logic [15:0] RST_IMG = slot_reset(g);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                slot_r[g] <= RST_IMG; // [RULE3] [RULE8]
            end else if (access && pwrite && hit_slot
                         && sidx == 2'(g)) begin
                // Bit 15 and bits 14:9 are stored as written. [RULE1] [RULE2]
                slot_r[g] <= pwdata[15:0]; // [RULE8]
            end
        end
    end

    // Control register holding the walker enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= SQS_RST_CTRL[0];
        end else if (access && pwrite && hit_ctrl) begin
            enable_r <= pwdata[0];
        end
    end

    // Bus answer: no wait state; ready with data or error in the first access cycle.
    // Registering the answer during setup costs no wait state, and it keeps every
    // bus output straight from a flip-flop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && bad;
            prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Walker steps the slot pointer on conversion completion.
    sqs_walker i_sqs_walker (
        .clk(clk),
        .rst_n(rst_n),
        .enable(enable_r),
        .conv_done(conv_done),
        .cur_entry(cur_entry),
        .slot_idx(walk_idx)
    );

    // Channel codes pass through unchanged; their meaning is the
    // primary channel-select encoding, which this block does not decode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_r <= '0;
        end else begin
            chan_r.converter_b_channel <= chan_b_pick; // [RULE6] [RULE9]
            chan_r.converter_a_channel <= chan_a_pick; // [RULE7] [RULE9]
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign chan_sel = chan_r;
    assign cur_slot = walk_idx;

    // A write to a slot appears on the next read of it.
    slot_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        access && pwrite && hit_slot
        |=> slot_r[$past(sidx)] == $past(pwdata[15:0]))
        else $error("slot write was not stored"); // [RULE8]

    // Converter B channel follows bits 7:4 of the current slot.
    chan_b_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 chan_r.converter_b_channel
            == $past(cur_entry.converter_b_channel))
        else $error("converter B channel mismatch"); // [RULE6]

    // Converter A channel follows bits 3:0 of the current slot.
    chan_a_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 chan_r.converter_a_channel
            == $past(cur_entry.converter_a_channel))
        else $error("converter A channel mismatch"); // [RULE7]

    // Ready comes exactly one cycle after setup and lasts one cycle.
    bus_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
        setup |=> pready_r ##1 !pready_r)
        else $error("ready not one cycle after setup");

    // The first slot keeps its address field while no write completes.
    addr_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(access && pwrite) |=> $stable(slot_r[0][SQS_ADDR_HI:SQS_ADDR_LO]))
        else $error("address field changed without write"); // [RULE3]

    // Access bit of the last slot only changes by a bus write.
    acc_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(access && pwrite) |=> $stable(slot_r[3][SQS_ACC_BIT]))
        else $error("access bit changed without write"); // [RULE1]

    // Checks on the bus answer and the control path follow.
    // An error answer always comes with ready, one cycle after setup.
    refuse_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        setup && bad |=> pslverr_r && pready_r)
        else $error("refusal not answered with error and ready");

    // Read data is zero outside the ready cycle.
    rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pready_r |-> prdata_r == 32'h0)
        else $error("read data outside the ready cycle");

    // A slot read returns the stored word in the lower half.
    slot_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        setup && !pwrite && hit_slot
        |=> prdata_r == $past({16'h0, slot_r[sidx]}))
        else $error("slot read data mismatch"); // [RULE8]

    // Status is read-only, so a write to it is refused.
    stat_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        setup && pwrite && hit_stat |=> pslverr_r)
        else $error("status write not refused");

    // Control write sets the walker enable.
    ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        access && pwrite && hit_ctrl |=> enable_r == $past(pwdata[0]))
        else $error("control write was not stored");

    // A refused write leaves the control bit and the first slot alone.
    refused_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        access && pwrite && bad
        |=> $stable(enable_r) && $stable(slot_r[0]))
        else $error("refused write changed a register");

    // A disabled walker parks on the first slot.
    walk_park_a: assert property (@(posedge clk) disable iff (!rst_n)
        !enable_r |=> walk_idx == 2'h0)
        else $error("disabled walker left the first slot");

endmodule : sqs_slots

// [sqs_slots_tb_top.sv]
`timescale 1ns/1ns
// Bench for the slot bank: APB access tasks and walker steps.
module sqs_slots_tb_top;
    import sqs_pkg::*;
    localparam logic [31:0] A_S12 = {24'h0, SQS_IDX_SLOT12, 2'b00};
    localparam logic [31:0] A_CTL = {24'h0, SQS_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_STA = {24'h0, SQS_IDX_STAT, 2'b00};
    logic clk = 1'b0; // Bench clock, 50 ns period.
    logic rst_n = 1'b0; // Reset held low at the start.
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_done = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic [31:0] prdata; // Read data, valid in the ready cycle.
    logic pready, pslverr;
    sqs_chan_t chan_sel; // Channel pair for the converters.
    logic [1:0] cur_slot;
    logic [31:0] rd; // Data taken at the last access edge.
    logic err; // Error flag taken at the last access edge.
    int n_mismatch = 0, checked = 0, cycles = 0;

    sqs_slots i_sqs_slots (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done), .chan_sel(chan_sel),
        .cur_slot(cur_slot));

    // Free-running clock.
    always #25 clk = ~clk;

    // Cuts a hang short; the tests need about 125 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            $display("unexpected at %0t: timeout", $time);
            close_out();
        end
    end

    // Prints the counts and the verdict, then stops.
    task close_out;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // Compares one value and reports a mismatch at once.
    task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, s, got,
                exp);
        end
    endtask : chk

    // One APB transfer; entered just after a rising edge.
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // The request stands until pready is seen high at an edge; only
        // the bench timeout ends a wait that never completes.
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // The slave answers with no wait state, at the first access edge.
        chk(32'(n), 32'h1, "wait states");
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next request out of this time step.
        @(posedge clk);
    endtask : apb

    // Reads a register and expects a clean answer with the given data.
    task rchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
        chk({31'h0, err}, 32'h0, "read error");
    endtask : rchk

    // Expects a refused access: error set and read data zero.
    task echk(input logic wr, input logic [31:0] a);
        apb(wr, a, 32'h0000_ffff);
        chk({31'h0, err}, 32'h1, "refusal");
        chk(rd, 32'h0, "refused data");
    endtask : echk

    // Programs slot k with its own address, a flag and channels k+4/k+1.
    task prog(input int k, input logic f);
        apb(1'b1, A_S12 + 4 * k, {16'h0, 1'b1, 6'(6'h2c + k), f,
            4'(k + 4), 4'(k + 1)});
    endtask : prog

    // One conversion-complete pulse, then the landed slot is checked.
    task step(input int s);
        logic [7:0] ech;
        ech = {4'(s + 4), 4'(s + 1)};
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({30'h0, cur_slot}, 32'(s), "slot");
        chk({24'h0, chan_sel}, {24'h0, ech}, "chan");
        @(posedge clk);
    endtask : step

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            rchk(A_S12 + 4 * k, 32'h5800 + 32'h200 * k);
        end
        rchk(A_CTL, 32'h0);
        chk({24'h0, chan_sel}, 32'h0, "reset chan");
        $display("test reset done");
        // Every field takes a new value; the upper half stays zero.
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, A_S12 + 4 * k, {16'ha5a5, 1'b1, 6'(6'h15 + k), 1'b1,
                4'(9 + k), 4'(3 + k)});
            rchk(A_S12 + 4 * k, {16'h0, 1'b1, 6'(6'h15 + k), 1'b1,
                4'(9 + k), 4'(3 + k)});
        end
        $display("test read write done");
        echk(1'b0, 32'h100);
        echk(1'b1, A_S12 + 1);
        echk(1'b1, A_STA);
        rchk(A_S12, 32'h0000_ab93);
        $display("test refusal done");
        // Flag set in slot 13 sends the walker back to slot 12.
        for (int k = 0; k < 4; k++) prog(k, k == 1);
        apb(1'b1, A_CTL, 32'h1);
        step(1);
        step(0);
        prog(1, 1'b0);
        for (int s = 1; s < 5; s++) step(s % 4);
        rchk(A_STA, {22'h0, 2'h0, 4'h4, 4'h1});
        step(1);
        apb(1'b1, A_CTL, 32'h0);
        #1;
        chk({30'h0, cur_slot}, 32'h0, "disabled slot");
        $display("test walker done");
        close_out();
    end
endmodule : sqs_slots_tb_top

// [sqs_walker.sv]
`timescale 1ns/1ns
// Walks the four slots on each conversion-complete pulse.
module sqs_walker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic conv_done,
    input wire sqs_pkg::sqs_entry_t cur_entry,
    output logic [1:0] slot_idx
);
    import sqs_pkg::*;

    // Index of the slot now in use.
    logic [1:0] slot_r;
    // Next value of the index.
    logic [1:0] slot_nxt;
    // Last slot wraps to the first as well, since slot 16 is not here.
    wire last_slot = (slot_r == 2'(SQS_SLOTS - 1));
    wire go_first = cur_entry.slot_return_flag | last_slot; // [RULE5]
    wire [1:0] slot_inc = slot_r + 2'h1; // [RULE4]

    assign slot_nxt = !enable ? 2'h0 :
                      !conv_done ? slot_r :
                      go_first ? 2'h0 : slot_inc;

    // Index register; a disabled walker sits on the first slot.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_r <= 2'h0;
        end else begin
            slot_r <= slot_nxt;
        end
    end

    assign slot_idx = slot_r;

    // Return flag sends the walk back to the first slot.
    return_jump_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && conv_done && cur_entry.slot_return_flag |=> slot_r == 2'h0)
        else $error("return flag did not restart the walk"); // [RULE5]

    // Cleared flag steps to the next slot.
    step_next_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && conv_done && !cur_entry.slot_return_flag && !last_slot
        |=> slot_r == $past(slot_r) + 2'h1)
        else $error("walk did not step to the next slot"); // [RULE4]

    // Without a completion the slot holds.
    slot_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        enable && !conv_done ##1 enable |-> $stable(slot_r))
        else $error("slot moved without a completion");

endmodule : sqs_walker
